// File: bpc_breakpoint.sv
/*
 * Breakpoint and trigger-qualification comparators A, B and C with an
 * APB register file. Assumes the core marks tagged instructions as they
 * reach execution and gives a pulse at each instruction boundary.
 */
// Overview of operation
// - Forced breaks are requested at the next instruction boundary after a match.
// - Tagged breaks mark the fetched instruction and break just before it executes.
// - Monitor select 1 requests debug entry; 0 requests a software interrupt.
// - Debug entry and software interrupt requests never coincide, forced and tagged.
// - Dual address mode gives two address breakpoints and no data matching.
// - One tag-select bit chooses forced or tagged for the A/B breakpoints.
// - Mask fields pick exact or range match and which address parts compare.
// - Forced breaks qualify on read, write or either via each rw bit pair.
// - Full mode breaks on A address and B data together, rw qualified.
// - Full mode with tagged type compares address only, ignoring data.
// - Full mode B mask picks data bytes; B rw bits are unused.
// - No breaks during debug firmware; no debug tagging during single step.
// - Debug controller and tag pin breaks take priority over these breaks.
// - Returning to a tagged instruction retags it unless settings changed.
// - Comparator C gives a third breakpoint with its own control bits.
// - With C at reset address, a tagged C break needs code at 0x0000.
// - In trace mode A compares address; B compares data in full modes.
// - Comparator C breaks or serves loop1; all matches go to the trace controller.
// - Page select 01 also compares the upper page bits from extended fields, except for A/B in breakpoint mode, which page on flash.
// - A tagged C break at an A/B tagged trigger address suppresses A/B.
// - A and B rw enables are ignored while trigger select is 1, except in event-only modes.
// - Full trace mode B compares data of the cycle kind A's rw bits allow.
// - Trigger select 1 qualifies A/B with opcode fetch, dropping B in full modes; 0 forces; not event-only.
// - Breakpoint mode overrides trace mode; trace mode is barred when secured.
`timescale 1ns/1ps

module bpc_breakpoint
	import bpc_pkg::*;
(
	input  wire logic        i_clock,        // Core bus clock, 10 MHz.
	input  wire logic        i_srst,         // Synchronous reset, high.
	input  wire bpc_apb_t    i_apb,          // APB request signals.
	output logic [31:0]      o_prdata,       // APB read data.
	output logic             o_pready,       // APB ready.
	output logic             o_pslverr,      // APB error, unmapped.
	input  wire bpc_bus_t    i_bus,          // Core bus cycle.
	input  wire logic        i_boundary,     // Instruction boundary.
	input  wire logic        i_tag_exec_ab,  // A/B tagged op executes.
	input  wire logic        i_tag_exec_c,   // C tagged op executes.
	input  wire logic        i_bdm_active,   // Debug firmware running.
	input  wire logic        i_trace_cmd,    // Single step running.
	input  wire logic        i_bdm_break,    // Debug controller break.
	input  wire logic        i_secure,       // Part is secured.
	output logic             o_tag_ab,       // Tag fetched op for A/B.
	output logic             o_tag_c,        // Tag fetched op for C.
	output logic             o_match_a,      // Match A to trace ctrl.
	output logic             o_match_b,      // Match B to trace ctrl.
	output logic             o_match_c,      // Match C to trace ctrl.
	output logic             o_bdm_req,      // Debug entry request.
	output logic             o_swi_req       // Software irq request.
);

	////////////////////////////////////////////////////////////////////
	// Registers and APB slave.

	logic [15:0] ctrl_reg;
	logic [3:0]  mask_reg;
	logic [23:0] cmp_reg [3];
	logic        fpend_reg;
	logic        live_ab_reg;
	logic        live_c_reg;
	logic        bkp_mode;
	logic        trace_mode;
	logic        setup;
	logic        addr_ok;
	logic        wr_en;
	logic        cfg_wr;
	logic [31:0] rd_mux;

	assign setup = i_apb.psel && !i_apb.penable;
	assign wr_en = i_apb.psel && i_apb.penable && o_pready
		&& i_apb.pwrite && addr_ok;
	assign cfg_wr = wr_en && (i_apb.paddr != BPC_STAT_OFS);

	always_comb
	begin
		addr_ok = 1'b1;
		rd_mux = 32'h00000000;
		case (i_apb.paddr)
			BPC_CTRL_OFS: rd_mux = {16'h0000, ctrl_reg};
			BPC_MASK_OFS: rd_mux = {28'h0000000, mask_reg};
			BPC_CMPA_OFS: rd_mux = {8'h00, cmp_reg[0]};
			BPC_CMPB_OFS: rd_mux = {8'h00, cmp_reg[1]};
			BPC_CMPC_OFS: rd_mux = {8'h00, cmp_reg[2]};
			BPC_STAT_OFS: rd_mux = {24'h000000, fpend_reg,
				live_c_reg, live_ab_reg, o_match_c, o_match_b,
				o_match_a, trace_mode, bkp_mode};
			default: addr_ok = 1'b0;
		endcase
	end

	// Ready comes one cycle after setup, so every access takes two cycles.
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready <= setup;
			o_prdata <= (setup && !i_apb.pwrite) ? rd_mux : 32'h00000000;
			o_pslverr <= setup && !addr_ok;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			ctrl_reg <= BPC_CTRL_RST;
			mask_reg <= BPC_MASK_RST;
			cmp_reg[0] <= BPC_CMP_RST;
			cmp_reg[1] <= BPC_CMP_RST;
			cmp_reg[2] <= BPC_CMP_RST;
		end
		else if (wr_en)
		begin
			case (i_apb.paddr)
				BPC_CTRL_OFS: ctrl_reg <= i_apb.pwdata[15:0];
				BPC_MASK_OFS: mask_reg <= i_apb.pwdata[3:0];
				BPC_CMPA_OFS: cmp_reg[0] <= i_apb.pwdata[23:0];
				BPC_CMPB_OFS: cmp_reg[1] <= i_apb.pwdata[23:0];
				BPC_CMPC_OFS: cmp_reg[2] <= i_apb.pwdata[23:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mode decode.

	logic full;
	logic mon_sel;
	logic ab_tagged_select;
	logic ctag;
	logic cen;
	logic trig_q;

	assign bkp_mode = ctrl_reg[BPC_BKP_EN];
	assign trace_mode = ctrl_reg[BPC_TRC_EN] && !bkp_mode
		&& !i_secure;
	assign full = ctrl_reg[BPC_FULL];
	assign mon_sel = ctrl_reg[BPC_MON_SEL];
	assign ab_tagged_select = ctrl_reg[BPC_TAG_AB];
	assign cen = ctrl_reg[BPC_C_EN];
	assign ctag = ctrl_reg[BPC_C_TAG];
	// Event-only modes ignore trigger select.
	assign trig_q = ctrl_reg[BPC_TRG_SEL]
		&& !ctrl_reg[BPC_EVT_ONLY];

	////////////////////////////////////////////////////////////////////
	// Address comparators A, B and C.

	logic [2:0] raw;
	logic [2:0] rwq;

	for (genvar i = 0; i < 3; i++)
	begin : g_cmp
		logic [1:0] mb;
		logic       pg;
		logic       xen;
		logic       hi_ok;
		logic       lo_ok;
		logic       x_ok;
		logic       rw_en;

		// Comparator C always compares exactly.
		assign mb = (i == 2) ? 2'b00 : mask_reg[2*(i % 2) +: 2];
		// Breakpoint mode pages A/B on flash accesses only.
		assign pg = bkp_mode && (i < 2) && i_bus.flash;
		assign xen = (bkp_mode && (i < 2)) ? i_bus.flash
			: (cmp_reg[i][BPC_PSEL_LSB +: 2] == 2'b01);
		assign x_ok = i_bus.page == cmp_reg[i][BPC_EXT_LSB +: 6];
		assign hi_ok = pg ? (i_bus.addr[13:8] == cmp_reg[i][13:8])
			: (i_bus.addr[15:8] == cmp_reg[i][15:8]);
		assign lo_ok = i_bus.addr[7:0] == cmp_reg[i][7:0];
		assign raw[i] = (!xen || x_ok) && (&mb || hi_ok)
			&& (mb[0] || lo_ok);
		assign rw_en = ctrl_reg[BPC_RWEN0 + 2*i]
			&& !((i < 2) && trig_q);
		assign rwq[i] = !rw_en
			|| (i_bus.rw == ctrl_reg[BPC_RWEN0 + 2*i + 1]);
	end

	////////////////////////////////////////////////////////////////////
	// Data comparator B in full modes.

	logic dmatch;
	logic dq;

	assign dmatch = (mask_reg[3] || i_bus.data[15:8] == cmp_reg[1][15:8])
		&& (mask_reg[2] || i_bus.data[7:0] == cmp_reg[1][7:0]);
	// Data is qualified by A's rw bits; B's own bits are ignored.
	assign dq = dmatch && rwq[0];

	////////////////////////////////////////////////////////////////////
	// Breakpoint mode hits.

	logic ab_forced;
	logic c_forced;
	logic fhit;
	logic tag_c_hit;
	logic tag_ab_hit;

	assign ab_forced = !ab_tagged_select && (full
		? (raw[0] && rwq[0] && dq)
		: ((raw[0] && rwq[0]) || (raw[1] && rwq[1])));
	assign c_forced = cen && !ctag && raw[2] && rwq[2];
	assign fhit = bkp_mode && (ab_forced || c_forced);
	assign tag_c_hit = bkp_mode && cen && ctag && raw[2]
		&& i_bus.fetch;
	// Tagged full mode checks the address alone.
	assign tag_ab_hit = bkp_mode && ab_tagged_select && i_bus.fetch
		&& (raw[0] || (!full && raw[1]))
		&& !tag_c_hit;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_tag_ab <= 1'b0;
			o_tag_c <= 1'b0;
		end
		else
		begin
			o_tag_ab <= tag_ab_hit;
			o_tag_c <= tag_c_hit;
		end
	end

	// A new match arriving as the pending break is taken stays pending.
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
			fpend_reg <= 1'b0;
		else
			fpend_reg <= fhit || (fpend_reg && !i_boundary
				&& bkp_mode);
	end

	// Tags stay live until software changes the settings.
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			live_ab_reg <= 1'b0;
			live_c_reg <= 1'b0;
		end
		else
		begin
			live_ab_reg <= o_tag_ab || (live_ab_reg && !cfg_wr);
			live_c_reg <= o_tag_c || (live_c_reg && !cfg_wr);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Break requests.

	logic brk_tag;
	logic brk_force;
	logic brk;

	assign brk_tag = bkp_mode
		&& ((i_tag_exec_ab && live_ab_reg && ab_tagged_select)
		|| (i_tag_exec_c && live_c_reg && cen && ctag))
		&& !(mon_sel && i_trace_cmd);
	assign brk_force = i_boundary && fpend_reg;
	assign brk = (brk_tag || brk_force) && !i_bdm_active
		&& !i_bdm_break;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_bdm_req <= 1'b0;
			o_swi_req <= 1'b0;
		end
		else
		begin
			o_bdm_req <= brk && mon_sel;
			o_swi_req <= brk && !mon_sel;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Trace mode matches toward the trace buffer controller.

	logic c_tag_t;
	logic ma;
	logic mb_t;

	assign c_tag_t = cen && ctag && raw[2] && i_bus.fetch;
	assign ma = raw[0] && (trig_q ? i_bus.fetch : rwq[0])
		&& !c_tag_t;
	// With trigger select set, full modes drop B matches.
	assign mb_t = (full ? (!trig_q && dq)
		: raw[1] && (trig_q ? i_bus.fetch : rwq[1]))
		&& !(trig_q && c_tag_t);

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_match_a <= 1'b0;
			o_match_b <= 1'b0;
			o_match_c <= 1'b0;
		end
		else
		begin
			o_match_a <= trace_mode && ma;
			o_match_b <= trace_mode && mb_t;
			o_match_c <= trace_mode && raw[2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);

	sequence s_setup;
		i_apb.psel && !i_apb.penable;
	endsequence

	sequence s_access;
		i_apb.psel && i_apb.penable && o_pready;
	endsequence

	sequence s_boundary_take;
		fpend_reg && i_boundary && !i_bdm_active && !i_bdm_break;
	endsequence

	a_apb_two_cycle: assert property (s_setup ##1 i_apb.psel
		|-> o_pready)
		else $error("ready missing after setup");

	a_apb_one_ready: assert property (s_access |=> !o_pready)
		else $error("ready held too long");

	a_mon_select: assert property (o_bdm_req |-> $past(mon_sel))
		else $error("debug request without monitor select");

	a_req_exclusive: assert property (!(o_bdm_req && o_swi_req))
		else $error("both requests at once");

	a_forced_take: assert property (s_boundary_take |=>
		(o_bdm_req || o_swi_req))
		else $error("pending forced break not taken");

	a_req_cause: assert property ((o_bdm_req || o_swi_req)
		|-> $past(i_boundary || i_tag_exec_ab || i_tag_exec_c))
		else $error("request without boundary or tag");

	a_bdm_quiet: assert property (i_bdm_active |=>
		!o_bdm_req && !o_swi_req)
		else $error("break during debug firmware");

	a_ext_prior: assert property (i_bdm_break |=>
		!o_bdm_req && !o_swi_req)
		else $error("break over debug controller");

	a_tag_fetch: assert property (o_tag_ab || o_tag_c
		|-> $past(i_bus.fetch && bkp_mode))
		else $error("tag without opcode fetch");

	a_c_over_ab: assert property (!(o_tag_ab && o_tag_c))
		else $error("A/B tag alongside C tag");

	a_trace_secure: assert property ((i_secure || bkp_mode)
		|=> !o_match_a && !o_match_b && !o_match_c)
		else $error("trace match while barred");

	a_retag_drop: assert property (cfg_wr && !o_tag_ab
		##1 (i_tag_exec_ab && !o_tag_ab && !i_tag_exec_c)
		|=> !o_bdm_req && !o_swi_req)
		else $error("stale tag broke after change");

endmodule

// File: bpc_core_model.sv
/*
 * Core-side partner of the breakpoint comparators: presents one bus cycle
 * per request, then an instruction boundary, and runs tagged opcodes.
 * Assumes the bench holds i_cyc steady after the one-cycle i_go pulse.
 */
`timescale 1ns/1ps

module bpc_core_model
	import bpc_pkg::*;
(
	input  wire logic     i_clock,       // Core bus clock.
	input  wire logic     i_srst,        // Synchronous reset, high.
	input  wire logic     i_go,          // Present i_cyc next cycle.
	input  wire bpc_bus_t i_cyc,         // Cycle to present.
	input  wire logic     i_tag_ab,      // Tag from comparators A/B.
	input  wire logic     i_tag_c,       // Tag from comparator C.
	output bpc_bus_t      o_bus,         // Core bus toward the block.
	output logic          o_boundary,    // Instruction boundary pulse.
	output logic          o_tag_exec_ab, // Tagged A/B opcode executes.
	output logic          o_tag_exec_c   // Tagged C opcode executes.
);
	logic       go_q;
	logic [1:0] tab_q;
	logic [1:0] tc_q;

	// Idle cycles show the inverse of the last cycle so nothing stale matches.
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_bus <= '0;
			go_q <= 1'b0;
			o_boundary <= 1'b0;
		end
		else
		begin
			o_bus <= i_go ? i_cyc : ~i_cyc;
			go_q <= i_go;
			o_boundary <= go_q;
		end
	end

	// A tagged opcode reaches execution two cycles after its tag.
	always_ff @(posedge i_clock)
	begin
		tab_q <= i_srst ? 2'h0 : {tab_q[0], i_tag_ab};
		tc_q <= i_srst ? 2'h0 : {tc_q[0], i_tag_c};
	end

	assign o_tag_exec_ab = tab_q[1];
	assign o_tag_exec_c = tc_q[1];
endmodule

// File: bpc_pkg.sv
/*
 * Shared constants and carrier types of the breakpoint comparator block.
 * Assumes an APB master with byte addresses and a 16-bit core bus.
 */
package bpc_pkg;

	// Register byte offsets.
	localparam logic [7:0] BPC_CTRL_OFS = 8'h00;
	localparam logic [7:0] BPC_MASK_OFS = 8'h04;
	localparam logic [7:0] BPC_CMPA_OFS = 8'h08;
	localparam logic [7:0] BPC_CMPB_OFS = 8'h0c;
	localparam logic [7:0] BPC_CMPC_OFS = 8'h10;
	localparam logic [7:0] BPC_STAT_OFS = 8'h14;

	// Control register bit positions.
	localparam int BPC_BKP_EN   = 0;
	localparam int BPC_TRC_EN   = 1;
	localparam int BPC_FULL     = 2;
	localparam int BPC_MON_SEL  = 3;
	localparam int BPC_TAG_AB   = 4;
	localparam int BPC_TRG_SEL  = 5;
	localparam int BPC_EVT_ONLY = 6;
	localparam int BPC_C_EN     = 7;
	localparam int BPC_RWEN0    = 8;
	localparam int BPC_C_TAG    = 14;

	// Comparator register field positions.
	localparam int BPC_EXT_LSB  = 16;
	localparam int BPC_PSEL_LSB = 22;

	// Values after reset.
	localparam logic [15:0] BPC_CTRL_RST = 16'h0000;
	localparam logic [3:0]  BPC_MASK_RST = 4'h0;
	localparam logic [23:0] BPC_CMP_RST  = 24'h000000;

	typedef struct packed {
		logic [15:0] addr;
		logic [5:0]  page;
		logic [15:0] data;
		logic        rw;
		logic        flash;
		logic        fetch;
	} bpc_bus_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} bpc_apb_t;

endpackage

// File: breakpoint_comparator_logic_bench.sv
/*
 * Self-checking bench of the breakpoint comparators over APB.
 * Assumes the core model drives the bus side and one wait-free access.
 */
`timescale 1ns/1ps

module breakpoint_comparator_logic_bench;
	import bpc_pkg::*;

	logic        clk;
	logic        srst;
	bpc_apb_t    apb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	bpc_bus_t    bus;
	bpc_bus_t    cyc;
	logic        go;
	logic        bnd;
	logic        tx_ab;
	logic        tx_c;
	logic        bdm_active;
	logic        trace_cmd;
	logic        bdm_break;
	logic        secure;
	logic        tag_ab;
	logic        tag_c;
	logic        ma;
	logic        mb;
	logic        mc;
	logic        monitor_entry_select;
	logic        software_interrupt_request;
	logic [31:0] rd;
	logic        err;
	logic [6:0]  seen;
	int          miscompares;
	int          checks_done;

	bpc_breakpoint u_bpc_breakpoint (.i_clock(clk), .i_srst(srst),
		.i_apb(apb), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_bus(bus), .i_boundary(bnd),
		.i_tag_exec_ab(tx_ab), .i_tag_exec_c(tx_c),
		.i_bdm_active(bdm_active), .i_trace_cmd(trace_cmd),
		.i_bdm_break(bdm_break), .i_secure(secure), .o_tag_ab(tag_ab),
		.o_tag_c(tag_c), .o_match_a(ma), .o_match_b(mb), .o_match_c(mc),
		.o_bdm_req(monitor_entry_select), .o_swi_req(software_interrupt_request));

	bpc_core_model u_bpc_core_model (.i_clock(clk), .i_srst(srst),
		.i_go(go), .i_cyc(cyc), .i_tag_ab(tag_ab), .i_tag_c(tag_c),
		.o_bus(bus), .o_boundary(bnd), .o_tag_exec_ab(tx_ab),
		.o_tag_exec_c(tx_c));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic xfer(logic wr, logic [7:0] a, logic [31:0] wd);
		int n;
		@(posedge clk);
		apb <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clk);
		apb.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (n > 16)
			begin
				miscompares++;
				report_and_stop();
			end
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask

	function automatic logic [31:0] b(int p);
		return 32'h1 << p;
	endfunction

	// Presents one bus cycle, then records requests, tags and matches.
	task automatic run(logic [15:0] a, logic rw, logic f, logic [15:0] d);
		@(posedge clk);
		cyc <= '{a, 6'h00, d, rw, 1'b0, f};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		seen = 7'h00;
		repeat (10)
		begin
			@(posedge clk);
			seen |= {tag_c, tag_ab, mc, mb, ma, software_interrupt_request, monitor_entry_select};
			if (monitor_entry_select === 1'b1 && software_interrupt_request === 1'b1)
				chk("both requests", 0, 1);
		end
	endtask

	task automatic t_reset();
		xfer(1'b0, BPC_CTRL_OFS, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		xfer(1'b0, BPC_MASK_OFS, 32'h0);
		chk("mask reset", 32'h0, rd);
		xfer(1'b0, BPC_CMPC_OFS, 32'h0);
		chk("cmp c reset", 32'h0, rd);
		xfer(1'b1, 8'h20, 32'hffff);
		chk("unmapped err", 1, err);
	endtask

	task automatic t_forced();
		xfer(1'b1, BPC_CMPA_OFS, 32'h1234);
		for (int m = 0; m < 2; m++)
		begin
			xfer(1'b1, BPC_CTRL_OFS, b(BPC_BKP_EN) | (m ? b(BPC_MON_SEL) : 0));
			run(16'h1234, 1'b1, 1'b0, 16'h0);
			chk("forced req", m ? 3'h1 : 3'h2, seen);
		end
	endtask

	task automatic t_rw();
		xfer(1'b1, BPC_CTRL_OFS, b(0) | b(3) | b(BPC_RWEN0) | b(9));
		run(16'h1234, 1'b0, 1'b0, 16'h0);
		chk("rw write", 3'h0, seen);
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("rw read", 3'h1, seen);
	endtask

	task automatic t_suppress();
		xfer(1'b1, BPC_CTRL_OFS, b(BPC_BKP_EN) | b(BPC_MON_SEL));
		bdm_active <= 1'b1;
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("in firmware", 3'h0, seen);
		bdm_active <= 1'b0;
		bdm_break <= 1'b1;
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("controller break", 3'h0, seen);
		bdm_break <= 1'b0;
	endtask

	task automatic t_tagged();
		xfer(1'b1, BPC_CTRL_OFS, b(0) | b(BPC_MON_SEL) | b(BPC_TAG_AB));
		run(16'h1234, 1'b1, 1'b1, 16'h0);
		chk("tagged req", 7'h21, seen);
		trace_cmd <= 1'b1;
		run(16'h1234, 1'b1, 1'b1, 16'h0);
		chk("tag in step", 7'h20, seen);
		trace_cmd <= 1'b0;
	endtask

	task automatic t_comp_c();
		xfer(1'b1, BPC_CMPC_OFS, 32'h0040);
		xfer(1'b1, BPC_CTRL_OFS, b(0) | b(BPC_MON_SEL) | b(BPC_C_EN));
		run(16'h0040, 1'b1, 1'b0, 16'h0);
		chk("c break", 3'h1, seen);
	endtask

	task automatic t_full();
		xfer(1'b1, BPC_CMPB_OFS, 32'hbeef);
		xfer(1'b1, BPC_CTRL_OFS, b(0) | b(BPC_FULL) | b(BPC_MON_SEL));
		run(16'h1234, 1'b1, 1'b0, 16'h0000);
		chk("full data miss", 3'h0, seen);
		run(16'h1234, 1'b1, 1'b0, 16'hbeef);
		chk("full data hit", 3'h1, seen);
	endtask

	task automatic t_trace();
		xfer(1'b1, BPC_CTRL_OFS, b(BPC_TRC_EN));
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("trace match a", 3'h4, seen);
		xfer(1'b1, BPC_CTRL_OFS, b(BPC_TRC_EN) | b(BPC_BKP_EN));
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("bkp overrides", 3'h2, seen);
	endtask

	task automatic t_trace_bc();
		xfer(1'b1, BPC_CMPB_OFS, 32'h1234);
		xfer(1'b1, BPC_CTRL_OFS, b(BPC_TRC_EN));
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("trace match a b", 7'h0c, seen);
		run(16'h0040, 1'b1, 1'b0, 16'h0);
		chk("trace match c", 7'h10, seen);
		secure <= 1'b1;
		run(16'h1234, 1'b1, 1'b0, 16'h0);
		chk("secured trace", 7'h00, seen);
		secure <= 1'b0;
	endtask

	task automatic t_tag_c();
		xfer(1'b1, BPC_CMPC_OFS, 32'h0);
		xfer(1'b1, BPC_CTRL_OFS, b(BPC_BKP_EN) | b(BPC_MON_SEL)
			| b(BPC_TAG_AB) | b(BPC_C_EN) | b(BPC_C_TAG)
			| b(BPC_RWEN0 + 4) | b(BPC_RWEN0 + 5));
		run(16'h5678, 1'b1, 1'b1, 16'h0);
		chk("c tag before zero", 7'h00, seen);
		run(16'h0000, 1'b1, 1'b1, 16'h0);
		chk("c tag at zero", 7'h41, seen);
		xfer(1'b1, BPC_CMPC_OFS, 32'h1234);
		run(16'h1234, 1'b1, 1'b1, 16'h0);
		chk("c over a/b tag", 7'h41, seen);
	endtask

	initial
	begin
		srst = 1'b1;
		apb = '0;
		cyc = '0;
		go = 1'b0;
		bdm_active = 1'b0;
		trace_cmd = 1'b0;
		bdm_break = 1'b0;
		secure = 1'b0;
		miscompares = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_forced();
		t_rw();
		t_suppress();
		t_tagged();
		t_comp_c();
		t_full();
		t_trace();
		t_trace_bc();
		t_tag_c();
		report_and_stop();
	end
endmodule
